/* src/iti_timer.sv */
// interval timer with interrupt, apb register slave
`timescale 1ns/1ns
`include "iti_cfg.svh"
module iti_timer #(
    parameter int TICK_CYCLES = `ITI_TICK_CYCLES
) (
    // clock, reset, enable
    input wire logic pclk,
    input wire logic presetn,
    input wire logic clk_en,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // interrupt and subroutine call
    output logic irq,
    output logic call_pulse,
    output logic [15:0] call_number
);

    // registers
    iti_pkg::iti_state_t state;
    iti_pkg::iti_state_t next_state;
    iti_pkg::iti_setting_t setval;
    iti_pkg::iti_progress_t progress;
    logic [15:0] subr;
    logic [15:0] act_count;
    logic [15:0] act_ivl;
    logic [15:0] act_subr;
    logic [15:0] tick_cnt;
    logic [1:0] irq_stat;
    logic [1:0] irq_mask;
    logic cmd_err;
    logic [31:0] rd_mux;

    function automatic logic bcd_ok(input logic [15:0] v);
        logic ok;
        ok = 1'b1;
        for (int i = 0; i < 4; i++) begin
            if (v[4*i +: 4] > 4'h9) begin
                ok = 1'b0;
            end
        end
        return ok;
    endfunction : bcd_ok

    // bus decode
    wire setup_done = psel & penable & ~pready;
    wire xfer = psel & penable & pready;
    wire aligned = (paddr[1:0] == 2'b00);
    wire hit_cmd = aligned & (paddr == `ITI_OFF_CMD);
    wire hit_setval = aligned & (paddr == `ITI_OFF_SETVAL);
    wire hit_subr = aligned & (paddr == `ITI_OFF_SUBR);
    wire hit_status = aligned & (paddr == `ITI_OFF_STATUS);
    wire hit_prog = aligned & (paddr == `ITI_OFF_PROGRESS);
    wire hit_elap = aligned & (paddr == `ITI_OFF_ELAPSED);
    wire hit_istat = aligned & (paddr == `ITI_OFF_IRQ_STAT);
    wire hit_imask = aligned & (paddr == `ITI_OFF_IRQ_MASK);
    wire hit_vector = aligned & (paddr == `ITI_OFF_VECTOR);
    wire hit_any = hit_cmd | hit_setval | hit_subr | hit_status |
                   hit_prog | hit_elap | hit_istat | hit_imask |
                   hit_vector;
    wire wr = xfer & pwrite;
    wire wr_cmd = wr & hit_cmd;
    wire wr_setval = wr & hit_setval;
    wire wr_subr = wr & hit_subr;
    wire wr_istat = wr & hit_istat;
    wire wr_imask = wr & hit_imask;

    // command decode
    iti_pkg::iti_cmd_t cmd;
    assign cmd = iti_pkg::iti_cmd_t'(pwdata);
    wire fn_oneshot = (cmd.code == `ITI_FN_ONESHOT);
    wire fn_sched = (cmd.code == `ITI_FN_SCHED);
    wire fn_read = (cmd.code == `ITI_FN_READ);
    wire fn_stop = (cmd.code == `ITI_FN_STOP);
    wire fn_start = fn_oneshot | fn_sched;

    // operand checks
    wire count_ok = bcd_ok(setval.count);
    wire ivl_ok = bcd_ok(setval.interval) &
                  (setval.interval >= `ITI_IVL_MIN) &
                  (setval.interval <= `ITI_IVL_MAX);
    wire subr_ok = bcd_ok(subr) & (subr <= `ITI_SUB_MAX);
    wire args_ok = count_ok & subr_ok & (cmd.immediate | ivl_ok);
    wire start_cmd = wr_cmd & fn_start & args_ok;
    wire stop_cmd = wr_cmd & fn_stop;
    wire read_cmd = wr_cmd & fn_read;
    wire bad_cmd = wr_cmd & ~(fn_read | fn_stop | (fn_start & args_ok));
    wire [15:0] start_ivl = cmd.immediate ? `ITI_IMM_IVL
                                          : setval.interval;
    wire running = (state != iti_pkg::ITI_IDLE);

    // base tick, restarted with every start
    wire tick_last = (tick_cnt == 16'(TICK_CYCLES - 1));
    wire tick = running & tick_last;
    wire [15:0] next_tick_cnt = (start_cmd | !running | tick_last) ?
                                16'h0000 : tick_cnt + 16'h0001;

    // counters
    wire [15:0] present_count;
    wire [15:0] done_count;
    wire [15:0] elapsed;
    wire [15:0] elapsed_stepped;
    wire dec_evt = tick & (elapsed_stepped == act_ivl);
    wire at_end = (present_count == 16'h0001) |
                  (present_count == 16'h0000);
    wire expire = dec_evt & at_end & ~start_cmd & ~stop_cmd;
    wire reload = expire & (state == iti_pkg::ITI_SCHED);
    wire count_clear = stop_cmd | (expire & ~reload);
    wire restart = start_cmd | reload;

    iti_bcd_cnt #(
        .DOWN(1'b1)
    ) u_present (
        .pclk(pclk),
        .presetn(presetn),
        .clk_en(clk_en),
        .clear(count_clear),
        .load(restart),
        .step(dec_evt & ~expire),
        .load_value(start_cmd ? setval.count : act_count),
        .value(present_count),
        .stepped()
    );

    iti_bcd_cnt #(
        .DOWN(1'b0)
    ) u_done (
        .pclk(pclk),
        .presetn(presetn),
        .clk_en(clk_en),
        .clear(count_clear | restart),
        .load(1'b0),
        .step(dec_evt),
        .load_value(16'h0000),
        .value(done_count),
        .stepped()
    );

    iti_bcd_cnt #(
        .DOWN(1'b0)
    ) u_elapsed (
        .pclk(pclk),
        .presetn(presetn),
        .clk_en(clk_en),
        .clear(stop_cmd | start_cmd | dec_evt),
        .load(1'b0),
        .step(tick),
        .load_value(16'h0000),
        .value(elapsed),
        .stepped(elapsed_stepped)
    );

    // mode control
    always_comb begin
        next_state = state;
        case (state)
            iti_pkg::ITI_IDLE: begin
                if (start_cmd) begin
                    next_state = fn_sched ? iti_pkg::ITI_SCHED
                                          : iti_pkg::ITI_ONESHOT;
                end
            end
            iti_pkg::ITI_ONESHOT: begin
                if (stop_cmd) begin
                    next_state = iti_pkg::ITI_IDLE;
                end else if (start_cmd) begin
                    next_state = fn_sched ? iti_pkg::ITI_SCHED
                                          : iti_pkg::ITI_ONESHOT;
                end else if (expire) begin
                    next_state = iti_pkg::ITI_IDLE;
                end
            end
            iti_pkg::ITI_SCHED: begin
                if (stop_cmd) begin
                    next_state = iti_pkg::ITI_IDLE;
                end else if (start_cmd) begin
                    next_state = fn_sched ? iti_pkg::ITI_SCHED
                                          : iti_pkg::ITI_ONESHOT;
                end
            end
            default: begin
                next_state = iti_pkg::ITI_IDLE;
            end
        endcase
    end

    // progress snapshot, zero when stopped
    iti_pkg::iti_progress_t next_progress;
    assign next_progress.done = running ? done_count
                                        : `ITI_RST_BCD;
    assign next_progress.interval = running ? act_ivl
                                            : `ITI_RST_BCD;
    assign next_progress.elapsed = running ? elapsed
                                           : `ITI_RST_BCD;

    // interrupt status, a new event wins over its clear
    wire [1:0] irq_evt;
    assign irq_evt[`ITI_IRQ_EXP] = expire;
    assign irq_evt[`ITI_IRQ_ERR] = bad_cmd;
    wire [1:0] irq_clr = wr_istat ? pwdata[1:0] : 2'b00;
    wire [1:0] next_irq_stat = (irq_stat & ~irq_clr) | irq_evt;
    wire [1:0] next_irq_mask = wr_imask ? pwdata[1:0] : irq_mask;
    wire next_irq = |(next_irq_stat & next_irq_mask);

    // read data
    always_comb begin
        rd_mux = `ITI_RST_WORD;
        if (hit_setval) begin
            rd_mux = setval;
        end else if (hit_subr) begin
            rd_mux = {16'h0000, subr};
        end else if (hit_status) begin
            rd_mux[`ITI_ST_RUN] = running;
            rd_mux[`ITI_ST_SCHED] = (state == iti_pkg::ITI_SCHED);
            rd_mux[`ITI_ST_ERR] = cmd_err;
        end else if (hit_prog) begin
            rd_mux = {progress.interval, progress.done};
        end else if (hit_elap) begin
            rd_mux = {16'h0000, progress.elapsed};
        end else if (hit_istat) begin
            rd_mux = {30'h0000_0000, irq_stat};
        end else if (hit_imask) begin
            rd_mux = {30'h0000_0000, irq_mask};
        end else if (hit_vector) begin
            rd_mux = {16'h0000, act_subr};
        end
    end

    // bus answer, one wait state
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= `ITI_RST_WORD;
        end else if (clk_en) begin
            pready <= setup_done;
            pslverr <= setup_done & ~hit_any;
            prdata <= (setup_done & ~pwrite) ? rd_mux : `ITI_RST_WORD;
        end
    end

    // software settings
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            setval <= `ITI_RST_WORD;
            subr <= `ITI_RST_BCD;
            irq_mask <= `ITI_RST_IRQ;
            irq_stat <= `ITI_RST_IRQ;
        end else if (clk_en) begin
            if (wr_setval) begin
                setval <= pwdata;
            end
            if (wr_subr) begin
                subr <= pwdata[15:0];
            end
            irq_mask <= next_irq_mask;
            irq_stat <= next_irq_stat;
        end
    end

    // active timing values, captured at start
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= iti_pkg::ITI_IDLE;
            act_count <= `ITI_RST_BCD;
            act_ivl <= `ITI_RST_BCD;
            act_subr <= `ITI_RST_BCD;
            tick_cnt <= 16'h0000;
        end else if (clk_en) begin
            state <= next_state;
            tick_cnt <= next_tick_cnt;
            if (start_cmd) begin
                act_count <= setval.count;
                act_ivl <= start_ivl;
                act_subr <= subr;
            end
        end
    end

    // progress read and command error flag
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            progress <= '0;
            cmd_err <= 1'b0;
        end else if (clk_en) begin
            if (read_cmd) begin
                progress <= next_progress;
            end
            if (wr_cmd) begin
                cmd_err <= bad_cmd;
            end
        end
    end

    // interrupt and subroutine call outputs
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq <= 1'b0;
            call_pulse <= 1'b0;
            call_number <= `ITI_RST_BCD;
        end else if (clk_en) begin
            irq <= next_irq;
            call_pulse <= expire;
            if (expire) begin
                call_number <= act_subr;
            end
        end
    end

endmodule : iti_timer

/* include/iti_cfg.svh */
// register map, field positions, codes, limits and timing of the timer
`ifndef ITI_CFG_SVH
`define ITI_CFG_SVH

// register byte offsets
`define ITI_OFF_CMD 8'h00
`define ITI_OFF_SETVAL 8'h04
`define ITI_OFF_SUBR 8'h08
`define ITI_OFF_STATUS 8'h0c
`define ITI_OFF_PROGRESS 8'h10
`define ITI_OFF_ELAPSED 8'h14
`define ITI_OFF_IRQ_STAT 8'h18
`define ITI_OFF_IRQ_MASK 8'h1c
`define ITI_OFF_VECTOR 8'h20

// function codes of the interval timer command (three bcd digits)
`define ITI_FN_ONESHOT 12'h000
`define ITI_FN_SCHED 12'h003
`define ITI_FN_READ 12'h006
`define ITI_FN_STOP 12'h010

// accepted operand ranges, bcd
`define ITI_IVL_MIN 16'h0005
`define ITI_IVL_MAX 16'h0320
`define ITI_SUB_MAX 16'h0049
`define ITI_IMM_IVL 16'h0010

// status and interrupt bit positions
`define ITI_ST_RUN 0
`define ITI_ST_SCHED 1
`define ITI_ST_ERR 2
`define ITI_IRQ_EXP 0
`define ITI_IRQ_ERR 1

// reset values
`define ITI_RST_WORD 32'h0000_0000
`define ITI_RST_BCD 16'h0000
`define ITI_RST_IRQ 2'h0

// base tick of 0.1 ms at a clock period of 8 ns
`define ITI_TICK_NS 100000
`define ITI_CLK_NS 8
`define ITI_TICK_CYCLES (`ITI_TICK_NS / `ITI_CLK_NS)

`endif

/* include/iti_pkg.sv */
// types shared by the interval timer files
package iti_pkg;

    typedef enum logic [1:0] {
        ITI_IDLE,
        ITI_ONESHOT,
        ITI_SCHED
    } iti_state_t;

    typedef struct packed {
        logic [15:0] interval;
        logic [15:0] count;
    } iti_setting_t;

    typedef struct packed {
        logic [18:0] spare;
        logic immediate;
        logic [11:0] code;
    } iti_cmd_t;

    typedef struct packed {
        logic [15:0] elapsed;
        logic [15:0] interval;
        logic [15:0] done;
    } iti_progress_t;

endpackage : iti_pkg

/* src/iti_bcd_cnt.sv */
// four digit bcd counter, counting up or down, with clear and load
`timescale 1ns/1ns
module iti_bcd_cnt #(
    parameter bit DOWN = 1'b0
) (
    // clock, reset, enable
    input wire logic pclk,
    input wire logic presetn,
    input wire logic clk_en,
    // control, clear wins over load, load over step
    input wire logic clear,
    input wire logic load,
    input wire logic step,
    input wire logic [15:0] load_value,
    // count and its value after one step
    output logic [15:0] value,
    output logic [15:0] stepped
);

    wire [4:0] chain;

    assign chain[0] = 1'b1;

    generate
        for (genvar i = 0; i < 4; i++) begin : g_digit
            wire [3:0] digit = value[4*i +: 4];
            wire wrap = DOWN ? (digit == 4'h0) : (digit == 4'h9);
            wire [3:0] moved = DOWN ? digit - 4'h1 : digit + 4'h1;
            wire [3:0] wrapped = DOWN ? 4'h9 : 4'h0;
            assign chain[i+1] = chain[i] & wrap;
            assign stepped[4*i +: 4] = !chain[i] ? digit :
                                       wrap ? wrapped : moved;
        end
    endgenerate

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            value <= 16'h0000;
        end else if (clk_en) begin
            if (clear) begin
                value <= 16'h0000;
            end else if (load) begin
                value <= load_value;
            end else if (step) begin
                value <= stepped;
            end
        end
    end

endmodule : iti_bcd_cnt

/* test/iti_timer_asserts.sv */
// port checker for the interval timer, bound into iti_timer
`timescale 1ns/1ns
module iti_timer_asserts #(
    parameter int TICK_CYCLES = 4
) (
    // clock, reset, enable
    input wire logic pclk,
    input wire logic presetn,
    input wire logic clk_en,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // interrupt and call
    input wire logic irq,
    input wire logic call_pulse,
    input wire logic [15:0] call_number
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    localparam int MIN_GAP = 5 * TICK_CYCLES;
    int gap;
    // cycles since the last call, saturating
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) gap <= 1000000;
        else if (call_pulse) gap <= 1;
        else if (gap < 1000000) gap <= gap + 1;
    end
    a_ready_wait_state: assert property (
        psel && penable && !$past(penable) && clk_en |=> pready)
        else $error("pready missing after one wait state");
    // a low clock enable legally freezes the answer
    a_ready_one_cycle: assert property (pready && clk_en |=> !pready)
        else $error("pready held too long");
    a_ready_needs_access: assert property (
        pready |-> $past(psel) && $past(penable))
        else $error("pready without access phase");
    a_err_with_ready: assert property (pslverr |-> pready)
        else $error("pslverr outside answer");
    a_rdata_idle_zero: assert property (!pready |-> prdata == 32'h0)
        else $error("prdata not zero outside answer");
    a_call_single: assert property (
        call_pulse && clk_en |=> !call_pulse [*8])
        else $error("call pulse repeated");
    a_call_spacing: assert property (call_pulse |-> gap >= MIN_GAP)
        else $error("calls closer than shortest interval");
    a_number_legal: assert property (
        call_pulse |-> call_number <= 16'h0049)
        else $error("subroutine number out of range");
    a_number_with_call: assert property (
        $changed(call_number) |-> call_pulse)
        else $error("call number moved without a call");
    a_irq_cause: assert property (
        $rose(irq) |-> call_pulse || $past(pready) || $past(pready, 2))
        else $error("irq rose without cause");
endmodule : iti_timer_asserts

bind iti_timer iti_timer_asserts #(.TICK_CYCLES(TICK_CYCLES)) i_asserts (
    .pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq),
    .call_pulse(call_pulse), .call_number(call_number));

/* test/interval_timer_interrupt_bench.sv */
// self-checking bench for the interval timer
`timescale 1ns/1ns
`include "iti_cfg.svh"
module interval_timer_interrupt_bench;
    localparam int TK = 4;
    typedef struct {
        logic [31:0] setval;
        logic [15:0] subr;
        logic [31:0] cmd;
        logic [31:0] status;
    } iti_row_t;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic clk_en = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic irq;
    logic call_pulse;
    logic [15:0] call_number;
    logic [31:0] rd;
    logic er;
    int fail_count = 0;
    int total_checks = 0;
    int pulses = 0;
    int cycles = 0;
    int n;
    int p0;
    // set value, subroutine, command, status after it
    iti_row_t rows [11] = '{
        '{32'h0005_0002, 16'h0023, 32'h000, 32'h1},
        '{32'h0005_0002, 16'h0023, 32'h010, 32'h0},
        '{32'h0320_9999, 16'h0049, 32'h003, 32'h3},
        '{32'h0320_9999, 16'h0049, 32'h010, 32'h0},
        '{32'h0004_0002, 16'h0023, 32'h000, 32'h4},
        '{32'h0321_0002, 16'h0023, 32'h003, 32'h4},
        '{32'h0005_0002, 16'h0050, 32'h000, 32'h4},
        '{32'h0005_000a, 16'h0023, 32'h000, 32'h4},
        '{32'h0005_0002, 16'h0023, 32'h005, 32'h4},
        '{32'h0000_0002, 16'h0023, 32'h1003, 32'h3},
        '{32'h0000_0002, 16'h0023, 32'h010, 32'h0}};

    iti_timer #(.TICK_CYCLES(TK)) i_iti_timer (
        .pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq),
        .call_pulse(call_pulse), .call_number(call_number));

    initial begin
        forever #4 pclk = ~pclk;
    end

    // cycle count for the hang limit, and calls seen
    always @(posedge pclk) begin
        cycles++;
        if (call_pulse === 1'b1) pulses++;
        if (cycles == 20000) begin
            fail_count++;
            conclude();
        end
    end

    task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic apb(logic w, logic [7:0] a, logic [31:0] d);
        int k;
        k = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            k++;
        end while (pready !== 1'b1 && k < 50);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (k >= 50) fail_count++;
    endtask : apb

    task automatic wr(logic [7:0] a, logic [31:0] d);
        apb(1'b1, a, d);
    endtask : wr

    task automatic rdc(string what, logic [7:0] a, logic [31:0] e);
        apb(1'b0, a, 32'h0);
        check(what, rd, e);
    endtask : rdc

    task automatic wait_call(int lim);
        n = 0;
        while (call_pulse !== 1'b1 && n < lim) begin
            @(posedge pclk);
            n++;
        end
    endtask : wait_call

    task automatic conclude();
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : conclude

    initial begin
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        for (int a = 0; a <= 32; a += 4) begin
            rdc("reset", a[7:0], 32'h0);
        end
        apb(1'b0, 8'h24, 32'h0);
        check("slverr", er, 1);
        $display("reset test done");
        foreach (rows[i]) begin
            wr(`ITI_OFF_SETVAL, rows[i].setval);
            wr(`ITI_OFF_SUBR, {16'h0, rows[i].subr});
            wr(`ITI_OFF_CMD, rows[i].cmd);
            rdc("status", `ITI_OFF_STATUS, rows[i].status);
        end
        rdc("err flag", `ITI_OFF_IRQ_STAT, 32'h2);
        wr(`ITI_OFF_IRQ_MASK, 32'h2);
        repeat (2) @(posedge pclk);
        check("irq err", irq, 1);
        wr(`ITI_OFF_IRQ_STAT, 32'h2);
        repeat (2) @(posedge pclk);
        check("irq clr", irq, 0);
        $display("command table done");
        wr(`ITI_OFF_IRQ_MASK, 32'h1);
        wr(`ITI_OFF_SETVAL, 32'h0005_0002);
        wr(`ITI_OFF_SUBR, 32'h23);
        wr(`ITI_OFF_CMD, 32'h000);
        p0 = pulses;
        repeat (26) @(posedge pclk);
        wr(`ITI_OFF_CMD, 32'h006);
        rdc("progress", `ITI_OFF_PROGRESS, 32'h0005_0001);
        rdc("elapsed", `ITI_OFF_ELAPSED, 32'h2);
        wait_call(20);
        check("expiry time", n >= 2 && n <= 6, 1);
        check("call number", call_number, 16'h0023);
        repeat (2) @(posedge pclk);
        check("irq expiry", irq, 1);
        rdc("halted", `ITI_OFF_STATUS, 32'h0);
        repeat (80) @(posedge pclk);
        check("one call", pulses - p0, 1);
        wr(`ITI_OFF_CMD, 32'h006);
        rdc("idle progress", `ITI_OFF_PROGRESS, 32'h0);
        rdc("idle elapsed", `ITI_OFF_ELAPSED, 32'h0);
        wr(`ITI_OFF_IRQ_STAT, 32'h1);
        repeat (2) @(posedge pclk);
        check("irq cleared", irq, 0);
        $display("one-shot test done");
        wr(`ITI_OFF_SETVAL, 32'h0005_0001);
        wr(`ITI_OFF_SUBR, 32'h49);
        wr(`ITI_OFF_CMD, 32'h003);
        p0 = pulses;
        repeat (90) @(posedge pclk);
        check("repeats", pulses - p0, 4);
        check("sched number", call_number, 16'h0049);
        wr(`ITI_OFF_CMD, 32'h010);
        repeat (60) @(posedge pclk);
        check("stopped", pulses - p0, 4);
        $display("scheduled test done");
        wr(`ITI_OFF_SETVAL, 32'h0005_0003);
        wr(`ITI_OFF_CMD, 32'h000);
        repeat (40) @(posedge pclk);
        wr(`ITI_OFF_SETVAL, 32'h0005_0001);
        wr(`ITI_OFF_CMD, 32'h000);
        wait_call(60);
        check("restart time", n >= 19 && n <= 23, 1);
        $display("restart test done");
        wr(`ITI_OFF_SETVAL, 32'h0000_0002);
        wr(`ITI_OFF_CMD, 32'h1000);
        wait_call(120);
        check("immediate time", n >= 79 && n <= 83, 1);
        $display("immediate test done");
        // a low clock enable holds the prescaler and the count
        wr(`ITI_OFF_SETVAL, 32'h0005_0001);
        wr(`ITI_OFF_CMD, 32'h000);
        p0 = pulses;
        clk_en <= 1'b0;
        repeat (30) @(posedge pclk);
        check("frozen call", pulses - p0, 0);
        clk_en <= 1'b1;
        wait_call(40);
        check("frozen time", n >= 19 && n <= 23, 1);
        $display("clock enable test done");
        // reset while the scheduled timer runs halts it for good
        wr(`ITI_OFF_CMD, 32'h003);
        wait_call(40);
        check("sched call", n >= 19 && n <= 23, 1);
        check("irq running", irq, 1);
        presetn <= 1'b0;
        @(posedge pclk);
        check("irq in reset", irq, 0);
        check("number in reset", call_number, 16'h0);
        @(posedge pclk);
        presetn <= 1'b1;
        p0 = pulses;
        rdc("status after reset", `ITI_OFF_STATUS, 32'h0);
        rdc("setval after reset", `ITI_OFF_SETVAL, 32'h0);
        repeat (40) @(posedge pclk);
        check("no call after reset", pulses - p0, 0);
        $display("mid-run reset test done");
        conclude();
    end
endmodule : interval_timer_interrupt_bench
